// ### pdm_pkg.sv
// Package for the power-die mode, interrupt and serial control block.
// Assumes a single 100 MHz system clock; all rates derive from it.
package pdm_pkg;
  // Clock rate and derived timing
  localparam int CLK_HZ          = 100_000_000;
  localparam int NREQ_TOUT_MS    = 150;   // Normal request timeout in ms
  localparam int WD_PERIOD_MS    = 150;   // Watchdog period, pin open
  localparam int IRQ_PULSE_US    = 10;    // Interrupt low pulse width
  localparam int RST_LOW_US      = 1000;  // Reset low after regulator on
  localparam int NREQ_TOUT_CYC   = NREQ_TOUT_MS * (CLK_HZ / 1000);
  localparam int WD_PERIOD_CYC   = WD_PERIOD_MS * (CLK_HZ / 1000);
  localparam int IRQ_PULSE_CYC   = IRQ_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int RST_LOW_CYC     = RST_LOW_US * (CLK_HZ / 1_000_000);
  // Control byte fields (write)
  localparam int CTL_MODE_LO     = 0;     // mode_select_bits [1:0]
  localparam int CTL_HS_A        = 2;     // switch_on_bit for out a
  localparam int CTL_HS_B        = 3;
  localparam int CTL_HS_C        = 4;
  localparam int CTL_LIN_PU      = 5;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // Mode select encodings
  localparam logic [1:0] MSEL_NORMAL = 2'h0;
  localparam logic [1:0] MSEL_STOP   = 2'h1;
  localparam logic [1:0] MSEL_SLEEP  = 2'h2;
  localparam logic [1:0] MSEL_WDTRIG = 2'h3;
  // Status byte fields (read)
  localparam int ST_WAKE1        = 0;
  localparam int ST_WAKE2        = 1;
  localparam int ST_SW_THERM     = 2;
  localparam int ST_REG_HEAT     = 3;
  localparam int ST_LOW_SUP      = 4;
  localparam int ST_HIGH_SUP     = 5;
  localparam int ST_BUS_WAKE     = 6;
  localparam int ST_IRQ_SRC      = 7;
  localparam int SPI_BITS        = 8;
  // Mode state machine
  typedef enum logic [2:0] {
    PDM_RESET   = 3'h0,
    PDM_NREQ    = 3'h1,
    PDM_NORMAL  = 3'h2,
    PDM_STOP    = 3'h3,
    PDM_SLEEP   = 3'h4
  } pdm_mode_t;
endpackage : pdm_pkg

// ### pdm_spi_if.sv
// Interface between the mode controller and its serial shifter.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface pdm_spi_if;
  logic [7:0] status;    // Status snapshot to send
  logic [7:0] rx_byte;   // Received control byte
  logic       rx_valid;  // One-cycle pulse: valid transfer ended
  logic       ss_rise;   // One-cycle pulse: any select release
  logic       ss_fall;   // One-cycle pulse: start of transfer
  modport shifter (input status, output rx_byte, rx_valid, ss_rise, ss_fall);
  modport ctrl    (output status, input rx_byte, rx_valid, ss_rise, ss_fall);
endinterface : pdm_spi_if

// ### pdm_spi_shift.sv
// Serial slave shifter: samples select, clock and data pins.
// Assumes pins are asynchronous; all pass two flip-flops first.
`timescale 1ns/1ps
module pdm_spi_shift (
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  input  wire logic i_ss_b,
  input  wire logic i_sck,
  input  wire logic i_mosi,
  output logic      o_miso,
  output logic      o_miso_oe,
  pdm_spi_if.shifter spi
);
  logic [2:0] s1, s2;      // Synchroniser stages
  logic       ss_d, sck_d; // Previous synced values for edges
  logic [7:0] sh, next_sh; // Shift register
  logic [3:0] cnt, next_cnt; // Sample edge count
  logic       miso, next_miso;
  logic       oe, next_oe;
  logic       ss, sck, ss_f, ss_r, sck_r, sck_f;

  // Two-flop synchroniser; first stage read only by second
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1 <= 3'h4;                      // Idle levels: deselected, clock low
      s2 <= 3'h4;                      // Matches sck_d, so no false edge
      ss_d <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      s1 <= {i_ss_b, i_sck, i_mosi};
      s2 <= s1;
      ss_d <= s2[2];
      sck_d <= s2[1];
    end
  end
  assign ss    = s2[2];
  assign sck   = s2[1];
  assign ss_f  = ss_d & ~ss;
  assign ss_r  = ~ss_d & ss;
  assign sck_r = ~sck_d & sck & ~ss;
  assign sck_f = sck_d & ~sck & ~ss;

  // Next shift state
  always_comb begin
    next_sh = sh;
    next_cnt = cnt;
    next_miso = miso;
    next_oe = oe;
    if (ss_f) begin
      next_sh = spi.status;            // [R19]
      next_cnt = 4'h0;
      next_oe = 1'b1;                  // [R19]
      next_miso = spi.status[7];
    end else if (ss) begin
      next_oe = 1'b0;                  // [R22]
    end else begin
      if (sck_r)
        next_miso = sh[7];             // [R20]
      if (sck_f) begin
        next_sh = {sh[6:0], s2[0]};    // [R20]
        if (cnt != 4'hF)
          next_cnt = cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sh <= 8'h00;
      cnt <= 4'h0;
      miso <= 1'b0;
      oe <= 1'b0;
    end else begin
      sh <= next_sh;
      cnt <= next_cnt;
      miso <= next_miso;
      oe <= next_oe;
    end
  end

  assign o_miso       = miso;
  assign o_miso_oe    = oe;
  assign spi.rx_byte  = sh;
  assign spi.rx_valid = ss_r & (cnt == 4'(pdm_pkg::SPI_BITS)); // [R21] [R22]
  assign spi.ss_rise  = ss_r;
  assign spi.ss_fall  = ss_f;
endmodule : pdm_spi_shift

// ### pdm_ctrl.sv
// Power-die control: modes, watchdog, interrupts, switch gating.
// Assumes a 100 MHz clock; analog detectors arrive as async levels.
//
// Overview of operation
// R1: Mode select bits choose normal, stop, sleep
// R2: Stop limits regulator; sleep turns it off
// R3: Stop exits by interrupt; sleep by reset
// R4: Stop wakes on bus, wake pins, select
// R5: Normal request applies first-trigger timeout
// R6: Normal run uses windowed watchdog
// R7: Stop/sleep disable watchdog, switches; bus recessive
// R8: Missing or early trigger fails watchdog
// R9: Grounded config pin disables watchdog
// R10: Four fault sources pulse interrupt, unmaskable
// R11: Source flag reported once then cleared
// R12: Low supply flag held, raises interrupt
// R13: High supply flag held, raises interrupt
// R14: Stop wake events pulse interrupt, unmaskable
// R15: Regulator heat warning held, raises interrupt
// R16: Switch overheat latches all switches off
// R17: Switch on needs bit and gate high
// R18: Each transfer is one byte both ways
// R19: Select fall drives output, snapshots status
// R20: Shift on rising, sample on falling
// R21: Exactly eight sample edges validate transfer
// R22: Select rise latches byte; output tristated
// R23: Latched flags clear after being read
// R24: Thermal re-enable needs read then write
// R25: Stop needs two consecutive stop commands
`timescale 1ns/1ps
module pdm_ctrl #(
  parameter int NREQ_TOUT = pdm_pkg::NREQ_TOUT_CYC, // Normal request timeout
  parameter int WD_PERIOD = pdm_pkg::WD_PERIOD_CYC, // Watchdog period
  parameter int RST_LOW   = pdm_pkg::RST_LOW_CYC    // Reset pulse length
) (
  input  wire logic       I_CLOCK,
  input  wire logic       I_RST_B,
  input  wire logic       I_SS_B,
  input  wire logic       I_SPI_SERIAL_CLOCK,
  input  wire logic       I_MOSI,
  output logic            O_MISO,
  output logic            O_MISO_OE,
  input  wire logic       I_WAKE_INPUT_ONE,
  input  wire logic       I_WAKE_INPUT_TWO,
  input  wire logic       I_BUS_WAKE,
  input  wire logic       I_WATCHDOG_CONFIG_PIN,
  input  wire logic       I_LOW_SUPPLY,
  input  wire logic       I_HIGH_SUPPLY,
  input  wire logic       I_REG_HOT,
  input  wire logic [2:0] I_SWITCH_HOT,
  input  wire logic       I_PWM_GATE_INPUT,
  output logic            O_HIGH_SIDE_OUT_A,
  output logic            O_HIGH_SIDE_OUT_B,
  output logic            O_HIGH_SIDE_OUT_C,
  output logic            O_IRQ_B,
  output logic            O_RST_B,
  output logic            O_REG_ON,
  output logic            O_REG_LIMIT,
  output logic            O_LIN_ACTIVE,
  output logic            O_SENSE_ACTIVE,
  output logic [1:0]      O_MODE
);
  localparam int IRQ_W = pdm_pkg::IRQ_PULSE_CYC;
  localparam int CW = 32;  // Timer width

  pdm_spi_if spi ();

  pdm_spi_shift u_shift (
    .i_clock   (I_CLOCK),
    .i_rst_b   (I_RST_B),
    .i_ss_b    (I_SS_B),
    .i_sck     (I_SPI_SERIAL_CLOCK),
    .i_mosi    (I_MOSI),
    .o_miso    (O_MISO),
    .o_miso_oe (O_MISO_OE),
    .spi       (spi.shifter)
  );

  // Synchronisers for asynchronous pins
  logic [9:0] a1, a2;
  logic w1_d, w2_d;  // Previous wake pin levels
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      a1 <= 10'h000;
      a2 <= 10'h000;
      w1_d <= 1'b0;
      w2_d <= 1'b0;
    end else begin
      a1 <= {I_WAKE_INPUT_ONE, I_WAKE_INPUT_TWO, I_BUS_WAKE, I_WATCHDOG_CONFIG_PIN,
             I_LOW_SUPPLY, I_HIGH_SUPPLY, I_REG_HOT, I_SWITCH_HOT};
      a2 <= a1;
      w1_d <= a2[9];
      w2_d <= a2[8];
    end
  end
  logic wk1, wk2, bus_wk, wd_en, low_s, high_s, reg_hot, sw_hot;
  assign wk1     = a2[9];
  assign wk2     = a2[8];
  assign bus_wk  = a2[7];
  assign wd_en   = a2[6];          // Grounded pin disables watchdog [R9]
  assign low_s   = a2[5];
  assign high_s  = a2[4];
  assign reg_hot = a2[3];
  assign sw_hot  = |a2[2:0];

  // State registers
  pdm_pkg::pdm_mode_t mode, next_mode;
  logic [7:0]    ctl, next_ctl;          // Control byte
  logic [CW-1:0] tmr, next_tmr;          // Mode / watchdog timer
  logic [CW-1:0] irq_t, next_irq_t;      // Interrupt pulse timer
  logic          stop_arm, next_stop_arm; // First stop command seen
  logic          sw_latch, next_sw_latch; // Thermal latch-off
  logic          therm_rd, next_therm_rd; // Thermal flag has been read
  logic          src, next_src;          // Source report pending
  logic [6:0]    src_b, next_src_b;      // Latched source bits
  logic          bus_fl, next_bus_fl;    // Latched bus wake flag
  logic [3:0]    flt_d, next_flt_d;      // Previous fault levels

  logic        active;
  logic [3:0]  flt;
  logic [3:0]  flt_rise;
  logic [6:0]  live;
  logic        wake_ev, wd_trig, wd_fail, open_win;
  logic [1:0]  msel;

  assign active   = (mode == pdm_pkg::PDM_NORMAL) | (mode == pdm_pkg::PDM_NREQ);
  assign flt      = active ? {low_s, high_s, reg_hot, sw_hot} : 4'h0; // [R12] [R13] [R15] [R16]
  assign flt_rise = flt & ~flt_d;
  assign msel     = spi.rx_byte[pdm_pkg::CTL_MODE_LO +: 2];
  assign wd_trig  = spi.rx_valid & (msel == pdm_pkg::MSEL_WDTRIG);
  // Window is the second half of the period; first half is closed
  assign open_win = tmr >= CW'(WD_PERIOD / 2);
  // Live status: held flags follow their conditions [R12] [R13] [R15]
  assign live = {bus_fl, flt[2], flt[3], flt[1], sw_latch, wk2, wk1};

  // Next-state logic
  always_comb begin
    next_mode = mode;
    next_ctl = ctl;
    next_tmr = tmr + CW'(1);
    next_irq_t = (irq_t != '0) ? irq_t - CW'(1) : irq_t;
    next_stop_arm = stop_arm;
    next_sw_latch = sw_latch;
    next_therm_rd = therm_rd;
    next_src = src;
    next_src_b = src_b;
    next_bus_fl = bus_fl;
    next_flt_d = flt;
    wake_ev = 1'b0;
    wd_fail = 1'b0;
    // Switch overheat latches off [R16]
    if (flt[0])
      next_sw_latch = 1'b1;
    // Read of a set latch records it; transfer read clears bus flag [R23]
    if (spi.rx_valid) begin
      if (sw_latch && !flt[0])
        next_therm_rd = 1'b1;          // [R24]
      if (bus_fl && !src)
        next_bus_fl = 1'b0;            // [R23]
      if (src)
        next_src = 1'b0;               // Report delivered once [R11]
      next_ctl = spi.rx_byte;          // [R22] [R18]
      // A fresh overheat in the same cycle beats the re-enable write
      if (therm_rd && !flt[0] && spi.rx_byte[pdm_pkg::CTL_HS_A +: 3] != 3'h0) begin
        next_sw_latch = 1'b0;          // [R24]
        next_therm_rd = 1'b0;
      end
    end
    // Fault interrupts in run modes; unmaskable [R10]
    if (flt_rise != 4'h0) begin
      next_irq_t = CW'(IRQ_W);
      next_src = 1'b1;                 // [R11]
      // Thermal latch only sets on this edge, so report the cause itself
      next_src_b = live | {4'h0, flt[0], 2'h0};
    end
    unique case (mode)
      pdm_pkg::PDM_RESET: begin
        next_ctl = pdm_pkg::CTL_RESET;
        next_stop_arm = 1'b0;
        if (tmr >= CW'(RST_LOW - 1)) begin
          next_mode = pdm_pkg::PDM_NREQ;
          next_tmr = '0;
        end
      end
      pdm_pkg::PDM_NREQ: begin
        if (wd_trig) begin
          next_mode = pdm_pkg::PDM_NORMAL;
          next_tmr = '0;
        end else if (wd_en && tmr >= CW'(NREQ_TOUT - 1))
          wd_fail = 1'b1;              // [R5]
      end
      pdm_pkg::PDM_NORMAL: begin
        if (wd_trig) begin
          if (wd_en && !open_win)
            wd_fail = 1'b1;            // Early trigger [R8]
          next_tmr = '0;
        end else if (wd_en && tmr >= CW'(WD_PERIOD - 1))
          wd_fail = 1'b1;              // Missing trigger [R6] [R8]
        if (spi.rx_valid && msel == pdm_pkg::MSEL_STOP) begin
          if (stop_arm)
            next_mode = pdm_pkg::PDM_STOP;  // [R25] [R1]
          next_stop_arm = ~stop_arm;
        end else if (spi.rx_valid) begin
          next_stop_arm = 1'b0;
          if (msel == pdm_pkg::MSEL_SLEEP)
            next_mode = pdm_pkg::PDM_SLEEP; // [R1]
        end
      end
      pdm_pkg::PDM_STOP: begin
        next_tmr = '0;
        next_stop_arm = 1'b0;
        // Wake: pin change, bus, select rise [R4]
        wake_ev = (wk1 ^ w1_d) | (wk2 ^ w2_d) | bus_wk | spi.ss_rise;
        if (wake_ev) begin
          next_mode = pdm_pkg::PDM_NREQ;
          next_irq_t = CW'(IRQ_W);       // [R3] [R14]
          next_src = 1'b1;               // [R11]
          next_src_b = {bus_wk, 4'h0, wk2 ^ w2_d, wk1 ^ w1_d};
          if (bus_wk)
            next_bus_fl = 1'b1;
        end
      end
      pdm_pkg::PDM_SLEEP: begin
        next_tmr = '0;
        next_stop_arm = 1'b0;
        // Select edge does not wake sleep [R4]
        wake_ev = (wk1 ^ w1_d) | (wk2 ^ w2_d) | bus_wk;
        if (wake_ev) begin
          next_mode = pdm_pkg::PDM_RESET; // [R3]
          next_src = 1'b1;
          next_src_b = {bus_wk, 4'h0, wk2 ^ w2_d, wk1 ^ w1_d};
          if (bus_wk)
            next_bus_fl = 1'b1;
        end
      end
      default: next_mode = pdm_pkg::PDM_RESET;
    endcase
    if (wd_fail) begin
      next_mode = pdm_pkg::PDM_RESET;
      next_tmr = '0;
    end
  end

  // Register all state
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mode <= pdm_pkg::PDM_RESET;
      ctl <= pdm_pkg::CTL_RESET;
      tmr <= '0;
      irq_t <= '0;
      stop_arm <= 1'b0;
      sw_latch <= 1'b0;
      therm_rd <= 1'b0;
      src <= 1'b0;
      src_b <= 7'h00;
      bus_fl <= 1'b0;
      flt_d <= 4'h0;
    end else begin
      mode <= next_mode;
      ctl <= next_ctl;
      tmr <= next_tmr;
      irq_t <= next_irq_t;
      stop_arm <= next_stop_arm;
      sw_latch <= next_sw_latch;
      therm_rd <= next_therm_rd;
      src <= next_src;
      src_b <= next_src_b;
      bus_fl <= next_bus_fl;
      flt_d <= next_flt_d;
    end
  end

  // Status snapshot: source report while pending, else live [R11]
  assign spi.status = src ? {1'b1, src_b} : {1'b0, live};

  // Gate pin is asynchronous too; two flops cost two clocks of lag
  logic       pwm_s1, pwm_s2; // Gate synchroniser stages
  logic [2:0] hs, next_hs;    // Switch drive, one bit per output
  // Switch gating: bit and gate, not latched, run modes only [R17] [R7]
  always_comb begin
    next_hs = 3'h0;                    // Off unless every condition holds
    if (active && !sw_latch && pwm_s2)
      next_hs = ctl[pdm_pkg::CTL_HS_A +: 3]; // [R16] [R17]
  end
  // Register gate synchroniser and switch drive
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pwm_s1 <= 1'b0;
      pwm_s2 <= 1'b0;
      hs <= 3'h0;
    end else begin
      pwm_s1 <= I_PWM_GATE_INPUT;
      pwm_s2 <= pwm_s1;
      hs <= next_hs;
    end
  end
  assign O_HIGH_SIDE_OUT_A = hs[0];
  assign O_HIGH_SIDE_OUT_B = hs[1];
  assign O_HIGH_SIDE_OUT_C = hs[2];

  // Mode outputs [R2] [R3] [R7]
  assign O_IRQ_B        = (irq_t == '0);
  assign O_RST_B        = (mode != pdm_pkg::PDM_RESET) & (mode != pdm_pkg::PDM_SLEEP);
  assign O_REG_ON       = (mode != pdm_pkg::PDM_SLEEP);
  assign O_REG_LIMIT    = (mode == pdm_pkg::PDM_STOP);
  assign O_LIN_ACTIVE   = active;
  assign O_SENSE_ACTIVE = (mode == pdm_pkg::PDM_NORMAL);
  assign O_MODE         = (mode == pdm_pkg::PDM_STOP) ? pdm_pkg::MSEL_STOP :
                          (mode == pdm_pkg::PDM_SLEEP) ? pdm_pkg::MSEL_SLEEP :
                          pdm_pkg::MSEL_NORMAL;
endmodule : pdm_ctrl

// ### pdm_ctrl_sva.sv
// Checker for the power-die control block, on its top ports.
// Assumes it is bound onto pdm_ctrl and only watches.
`timescale 1ns/1ps
module pdm_ctrl_sva #(
  parameter int NREQ_TOUT = 200 // Request timeout cycles
) (
  input wire logic       I_CLOCK,
  input wire logic       I_RST_B,
  input wire logic       I_SS_B,
  input wire logic       I_WATCHDOG_CONFIG_PIN,
  input wire logic       I_PWM_GATE_INPUT,
  input wire logic       O_MISO_OE,
  input wire logic       O_HIGH_SIDE_OUT_A,
  input wire logic       O_HIGH_SIDE_OUT_B,
  input wire logic       O_HIGH_SIDE_OUT_C,
  input wire logic       O_IRQ_B,
  input wire logic       O_RST_B,
  input wire logic       O_REG_ON,
  input wire logic       O_REG_LIMIT,
  input wire logic       O_LIN_ACTIVE,
  input wire logic       O_SENSE_ACTIVE,
  input wire logic [1:0] O_MODE
);
  localparam int IRQ_LEN = pdm_pkg::IRQ_PULSE_CYC; // Pulse width
  logic [15:0] irq_cnt, next_irq_cnt; // Interrupt low run
  logic [15:0] req_cnt, next_req_cnt; // Watched request time
  wire         sw_any = O_HIGH_SIDE_OUT_A | O_HIGH_SIDE_OUT_B | O_HIGH_SIDE_OUT_C;
  // Run lengths; counters stay far below wrap in a bench run
  always_comb begin
    next_irq_cnt = O_IRQ_B ? 16'h0000 : irq_cnt + 16'h0001;
    next_req_cnt = 16'h0000;
    if (O_LIN_ACTIVE && !O_SENSE_ACTIVE && I_WATCHDOG_CONFIG_PIN) begin
      next_req_cnt = req_cnt + 16'h0001;
    end
  end
  // Register the counters
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      irq_cnt <= 16'h0000;
      req_cnt <= 16'h0000;
    end else begin
      irq_cnt <= next_irq_cnt;
      req_cnt <= next_req_cnt;
    end
  end
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);
  a_irq_width: assert property ($rose(O_IRQ_B) |-> irq_cnt == IRQ_LEN)
    else $error("interrupt pulse width wrong");
  a_req_tout: assert property (req_cnt <= NREQ_TOUT + 8)
    else $error("request timeout missed");
  a_sleep_out: assert property (O_MODE == 2'h2 |-> !O_REG_ON && !O_RST_B)
    else $error("sleep outputs wrong");
  a_stop_out: assert property (O_MODE == 2'h1 |-> O_REG_ON && O_REG_LIMIT && O_RST_B
    && !O_LIN_ACTIVE)
    else $error("stop outputs wrong");
  a_low_pwr_off: assert property ((O_MODE != 2'h0) [*2] |-> !sw_any && !O_SENSE_ACTIVE)
    else $error("switches on in low power");
  // Gate passes two synchroniser flops and the output flop
  a_switch_gate: assert property (sw_any |-> $past(I_PWM_GATE_INPUT, 3))
    else $error("switch on without gate");
  a_miso_hiz: assert property (I_SS_B [*5] |-> !O_MISO_OE)
    else $error("output driven while deselected");
  a_miso_drive: assert property ((!I_SS_B && O_RST_B && O_MODE == 2'h0) [*5]
    |-> O_MISO_OE)
    else $error("output not driven in frame");
  a_stop_wake: assert property (O_MODE == 2'h1 ##1 O_MODE == 2'h0
    |-> ##[0:8] !O_IRQ_B)
    else $error("stop exit without interrupt");
  a_sleep_wake: assert property (O_MODE == 2'h2 ##1 O_MODE != 2'h2
    |-> O_REG_ON && !O_RST_B)
    else $error("sleep exit without reset");
endmodule : pdm_ctrl_sva
bind pdm_ctrl pdm_ctrl_sva #(.NREQ_TOUT(NREQ_TOUT)) pdm_ctrl_sva_i (
  .I_CLOCK               (I_CLOCK),
  .I_RST_B               (I_RST_B),
  .I_SS_B                (I_SS_B),
  .I_WATCHDOG_CONFIG_PIN (I_WATCHDOG_CONFIG_PIN),
  .I_PWM_GATE_INPUT      (I_PWM_GATE_INPUT),
  .O_MISO_OE             (O_MISO_OE),
  .O_HIGH_SIDE_OUT_A     (O_HIGH_SIDE_OUT_A),
  .O_HIGH_SIDE_OUT_B     (O_HIGH_SIDE_OUT_B),
  .O_HIGH_SIDE_OUT_C     (O_HIGH_SIDE_OUT_C),
  .O_IRQ_B               (O_IRQ_B),
  .O_RST_B               (O_RST_B),
  .O_REG_ON              (O_REG_ON),
  .O_REG_LIMIT           (O_REG_LIMIT),
  .O_LIN_ACTIVE          (O_LIN_ACTIVE),
  .O_SENSE_ACTIVE        (O_SENSE_ACTIVE),
  .O_MODE                (O_MODE)
);

// ### pdm_spi_master.sv
// Serial master model for the companion controller.
// Assumes frames are framed by select; clock still between them.
`timescale 1ns/1ps
module pdm_spi_master (
  output logic      o_ss_b,
  output logic      o_sck,
  output logic      o_mosi,
  input  wire logic i_miso,
  input  wire logic i_miso_oe
);
  // Idle: deselected, clock low
  initial begin
    o_ss_b = 1'b1;
    o_sck  = 1'b0;
    o_mosi = 1'b0;
  end
  // One frame; a count other than 8 provokes refusal
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    o_ss_b = 1'b0;
    #500;
    for (int i = 0; i < n; i++) begin
      o_sck  = 1'b1;
      o_mosi = tx[7 - (i % 8)];
      #62.5;
      rx = {rx[6:0], i_miso_oe ? i_miso : ~rx[0]};
      o_sck = 1'b0;
      #62.5;
    end
    #200;
    o_ss_b = 1'b1;
    o_mosi = ~o_mosi; // No stale bit once released
    #500;
  endtask : xfer
endmodule : pdm_spi_master

// ### pdm_ctrl_tb.sv
// Testbench for the power-die control block.
// Assumes the serial master model and the bound checker.
`timescale 1ns/1ps
module pdm_ctrl_tb;
  localparam int TOUT = 2000; // Short request timeout
  logic       clk, rst_b, sck, ss_b, mosi, miso, miso_oe;
  logic       w1, w2, bw, wdp, lo, hi, rh, pwm; // Driven levels
  logic [2:0] sh;                               // Switch heat
  logic       ha, hb, hc, irq_b, rst_o, reg_on, reg_lim, lin, sense;
  logic [1:0] mode;
  logic [7:0] r;                                // Last status
  int         n_errors, samples_checked, i, k;
  time        t0;
  wire  [7:0] pins = {mode, reg_on, reg_lim, lin, sense, rst_o, ha | hb | hc};
  wire  [7:0] sw = {5'h00, ha, hb, hc};
  // Row: control byte, gate level, expected a,b,c
  logic [11:0] rows [6] = '{12'h1CF, 12'h1C0, 12'h04C, 12'h08A, 12'h109, 12'h008};
  logic [7:0]  fm [4] = '{8'h10, 8'h20, 8'h08, 8'h04}; // Fault flag bits
  initial clk = 1'b0;
  always #5 clk = ~clk;
  pdm_ctrl #(.NREQ_TOUT(TOUT), .WD_PERIOD(2000), .RST_LOW(20)) pdm_ctrl_i (
    .I_CLOCK(clk), .I_RST_B(rst_b), .I_SS_B(ss_b), .I_SPI_SERIAL_CLOCK(sck),
    .I_MOSI(mosi), .O_MISO(miso), .O_MISO_OE(miso_oe), .I_WAKE_INPUT_ONE(w1),
    .I_WAKE_INPUT_TWO(w2), .I_BUS_WAKE(bw), .I_WATCHDOG_CONFIG_PIN(wdp),
    .I_LOW_SUPPLY(lo), .I_HIGH_SUPPLY(hi), .I_REG_HOT(rh), .I_SWITCH_HOT(sh),
    .I_PWM_GATE_INPUT(pwm), .O_HIGH_SIDE_OUT_A(ha), .O_HIGH_SIDE_OUT_B(hb),
    .O_HIGH_SIDE_OUT_C(hc), .O_IRQ_B(irq_b), .O_RST_B(rst_o), .O_REG_ON(reg_on),
    .O_REG_LIMIT(reg_lim), .O_LIN_ACTIVE(lin), .O_SENSE_ACTIVE(sense), .O_MODE(mode));
  pdm_spi_master pdm_spi_master_i (.o_ss_b(ss_b), .o_sck(sck), .o_mosi(mosi),
    .i_miso(miso), .i_miso_oe(miso_oe));
  // Compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // Clock edges, then settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // One full byte frame, then realign stimulus to just after an edge
  task automatic x(input logic [7:0] t);
    pdm_spi_master_i.xfer(t, 8, r);
    cyc(1);
  endtask : x
  // Bounded wait: 0 interrupt, 1 reset out, 2 sense
  task automatic wt(input int s, input logic v);
    int j;
    for (j = 0; j < 5000; j++) begin
      if ((s == 0 ? irq_b : s == 1 ? rst_o : sense) === v) break;
      cyc(1);
    end
    if (j == 5000) begin
      n_errors++;
      $display("[FAIL] %0t wait %0d timed out", $time, s);
      finish_test();
    end
  endtask : wt
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  // Counts, verdict, end
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    {rst_b, w1, w2, bw, lo, hi, rh, pwm} = 8'h00;
    sh = 3'h0;
    wdp = 1'b1;
    cyc(5);
    chk({irq_b, miso_oe, sw[2:0], 3'h0}, 8'h80);
    chk(pins, 8'h20);
    rst_b = 1'b1;
    wt(1, 1'b1);
    chk(pins, 8'h2A);
    done("reset");
    t0 = $time;
    wt(1, 1'b0);
    chk({7'h00, ($time - t0 > TOUT * 10 - 100) && ($time - t0 < TOUT * 10 + 100)}, 8'h01);
    wt(1, 1'b1);
    x(8'h03);
    wt(2, 1'b1);
    x(8'h03);
    wt(1, 1'b0);
    wt(1, 1'b1);
    x(8'h03);
    wt(2, 1'b1);
    cyc(1300);
    x(8'h03);
    cyc(100);
    chk(pins, 8'h2E);
    wt(2, 1'b0);
    chk(pins, 8'h20);
    wdp = 1'b0;
    wt(1, 1'b1);
    x(8'h03);
    wt(2, 1'b1);
    cyc(3000);
    chk(pins, 8'h2E);
    done("watchdog");
    for (i = 0; i < 6; i++) begin
      cyc(1);
      pwm = rows[i][3];
      x(rows[i][11:4]);
      cyc(5);
      chk(sw, {5'h00, rows[i][2:0]});
    end
    done("switches");
    cyc(1);
    pwm = 1'b1;
    x(8'h1C);
    for (k = 0; k < 4; k++) begin
      {lo, hi, rh} = 3'h4 >> k;
      sh = {2'h0, k == 3};
      wt(0, 1'b0);
      wt(0, 1'b1);
      x(8'h1C);
      chk(r, 8'h80 | fm[k]);
      x(8'h1C);
      chk(r, fm[k]);
      {lo, hi, rh} = 3'h0;
    end
    chk(sw, 8'h00);
    sh = 3'h0;
    x(8'h1C);
    chk(r, 8'h04);
    chk(sw, 8'h00);
    x(8'h1C);
    cyc(5);
    chk(sw, 8'h07);
    done("faults");
    for (k = 7; k < 10; k += 2) begin
      pdm_spi_master_i.xfer(8'h02, k, r);
      cyc(5);
      chk(pins, 8'h2F);
    end
    done("count");
    for (k = 0; k < 3; k++) begin
      x(8'h03);
      wt(2, 1'b1);
      x(8'h01);
      x(8'h1C);
      cyc(5);
      chk(pins, 8'h2F);
      x(8'h01);
      x(8'h01);
      cyc(5);
      chk(pins, 8'h72);
      cyc(1);
      if (k == 0) w1 = 1'b1;
      if (k == 1) bw = 1'b1;
      if (k == 2) x(8'h00);
      wt(0, 1'b0);
      cyc(5);
      chk(pins, 8'h2A);
      x(8'h00);
      chk(r, k == 0 ? 8'h81 : k == 1 ? 8'hC0 : 8'h80);
      {w1, bw} = 2'h0;
    end
    done("stop");
    x(8'h03);
    wt(2, 1'b1);
    x(8'h02);
    cyc(5);
    chk(pins, 8'h80);
    x(8'h00);
    cyc(5);
    chk(pins, 8'h80);
    w2 = 1'b1;
    cyc(5);
    chk(pins, 8'h20);
    wt(1, 1'b1);
    chk(pins, 8'h2A);
    done("sleep");
    finish_test();
  end
endmodule : pdm_ctrl_tb
